// >>> hw/nvtk_port.sv
// Timekeeping RAM: byte bus, storage, BCD calendar counters and power-fail gate.
`timescale 1ns/1ps
`default_nettype none
`include "nvtk_consts.svh"

module nvtk_port #(
  parameter int unsigned SEC_CYCLES = `NVTK_SEC_CYCLES,
  parameter int unsigned REC_CYCLES = `NVTK_REC_CYCLES,
  parameter int unsigned AW         = 13,
  parameter int unsigned DW         = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire nvtk_pkg::nvtk_bus_t bus_i,
  output logic      [DW-1:0]    dq_o,
  output logic                  dq_oe_o,
  input  wire logic             power_ok_i,
  input  wire logic             backup_cell_low_i,
  output logic                  por_n_o
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (AW != 13 || DW != 8) begin : g_bad_geom
    $error("Only an 8192 by 8 organisation is supported.");
  end
  if (SEC_CYCLES < 2 || REC_CYCLES < 1) begin : g_bad_time
    $error("Second and recovery counts must be positive.");
  end

  localparam int unsigned PW = $clog2(SEC_CYCLES);
  localparam int unsigned RW = $clog2(REC_CYCLES + 1);
  localparam int unsigned DEPTH = 1 << AW;

  // ---------------------------------------------------------------------------
  // BCD helpers
  // ---------------------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Every fourth year is a leap year; this is exact for 2000 through 2099.
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4] == 1'b0) begin
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
  endfunction

  function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02: month_len = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  nvtk_pkg::nvtk_pf_t pf_state;
  nvtk_pkg::nvtk_pf_t next_pf_state;
  logic               access_ok;
  logic               selected;
  logic               wr;
  logic               rd;
  logic               in_clk;
  logic [2:0]         idx;

  assign access_ok = (pf_state == nvtk_pkg::NVTK_PF_ON);
  // Internal chip select is forced off whenever the power gate is closed.
  assign selected  = access_ok && !bus_i.chip_sel_n && bus_i.second_chip_select;
  assign wr        = selected && !bus_i.wr_en_n;
  assign rd        = selected && bus_i.wr_en_n && !bus_i.out_en_n;
  assign in_clk    = (bus_i.addr >= `NVTK_CLK_BASE);
  assign idx       = bus_i.addr[2:0];
  assign dq_oe_o   = rd;

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge mclk_i) begin
    if (wr && !in_clk) begin
      mem[bus_i.addr] <= bus_i.wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Counters, prescaler and host-visible copy
  // ---------------------------------------------------------------------------
  nvtk_pkg::nvtk_time_t tc;
  nvtk_pkg::nvtk_time_t next_tc;
  logic [PW-1:0]        pre;
  logic [PW-1:0]        next_pre;
  logic [7:0]           ureg [8];
  logic [7:0]           next_ureg [8];
  logic                 tick;
  logic                 whold;
  logic                 rhold;
  logic                 load;

  assign whold = ureg[`NVTK_IDX_CTRL][`NVTK_WHOLD_BIT];
  assign rhold = ureg[`NVTK_IDX_CTRL][`NVTK_RHOLD_BIT];
  assign tick  = (pre == PW'(SEC_CYCLES - 1));
  // Clearing the write-hold bit hands the staged bytes to the counters.
  assign load  = wr && in_clk && (idx == `NVTK_IDX_CTRL) && whold
                 && !bus_i.wdata[`NVTK_WHOLD_BIT];

  always_comb begin
    next_pre = tick ? '0 : pre + PW'(1);
    next_tc  = tc;
    if (tick) begin
      next_tc.sec = bcd_inc(tc.sec);
      if (tc.sec == `NVTK_MAX_SEC) begin
        next_tc.sec = `NVTK_RST_ZERO;
        next_tc.min = bcd_inc(tc.min);
        if (tc.min == `NVTK_MAX_SEC) begin
          next_tc.min  = `NVTK_RST_ZERO;
          next_tc.hour = bcd_inc(tc.hour);
          if (tc.hour == `NVTK_MAX_HOUR) begin
            next_tc.hour = `NVTK_RST_ZERO;
            next_tc.day  = (tc.day == `NVTK_MAX_DAY) ? `NVTK_RST_DAY : bcd_inc(tc.day);
            next_tc.date = bcd_inc(tc.date);
            if (tc.date == month_len(tc.month, tc.year)) begin
              next_tc.date  = `NVTK_RST_DATE;
              next_tc.month = bcd_inc(tc.month);
              if (tc.month == `NVTK_MAX_MONTH) begin
                next_tc.month = `NVTK_RST_MONTH;
                next_tc.year  = bcd_inc(tc.year);
                if (tc.year == `NVTK_MAX_YEAR) begin
                  next_tc.year = `NVTK_RST_YEAR;
                  next_tc.cent = bcd_inc(tc.cent);
                end
              end
            end
          end
        end
      end
    end
    if (load) begin
      next_tc.cent  = {2'b00, bus_i.wdata[5:0]};
      next_tc.year  = ureg[`NVTK_IDX_YEAR];
      next_tc.month = ureg[`NVTK_IDX_MONTH];
      next_tc.date  = ureg[`NVTK_IDX_DATE];
      next_tc.day   = ureg[`NVTK_IDX_DAY];
      next_tc.hour  = ureg[`NVTK_IDX_HOUR];
      next_tc.min   = ureg[`NVTK_IDX_MIN];
      next_tc.sec   = ureg[`NVTK_IDX_SEC];
      next_pre      = '0;
    end
  end

  // The copy follows the counters every cycle unless either hold bit is set,
  // so a read made while the read-hold bit is set sees one coherent, already-settled set of bytes.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      next_ureg[i] = ureg[i];
    end
    if (!whold && !rhold) begin
      next_ureg[`NVTK_IDX_CTRL] = {ureg[`NVTK_IDX_CTRL][7:6], tc.cent[5:0]};
      next_ureg[`NVTK_IDX_SEC]   = tc.sec;
      next_ureg[`NVTK_IDX_MIN]   = tc.min;
      next_ureg[`NVTK_IDX_HOUR]  = tc.hour;
      next_ureg[`NVTK_IDX_DAY]   = tc.day;
      next_ureg[`NVTK_IDX_DATE]  = tc.date;
      next_ureg[`NVTK_IDX_MONTH] = tc.month;
      next_ureg[`NVTK_IDX_YEAR]  = tc.year;
    end
    if (wr && in_clk) begin
      next_ureg[idx] = bus_i.wdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tc.cent  <= `NVTK_RST_CENT;
      tc.year  <= `NVTK_RST_YEAR;
      tc.month <= `NVTK_RST_MONTH;
      tc.date  <= `NVTK_RST_DATE;
      tc.day   <= `NVTK_RST_DAY;
      tc.hour  <= `NVTK_RST_ZERO;
      tc.min   <= `NVTK_RST_ZERO;
      tc.sec   <= `NVTK_RST_ZERO;
      pre      <= '0;
      for (int i = 0; i < 8; i++) begin
        ureg[i] <= `NVTK_RST_ZERO;
      end
    end else begin
      tc   <= next_tc;
      pre  <= next_pre;
      ureg <= next_ureg;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  logic [DW-1:0] next_dq;

  always_comb begin
    next_dq = mem[bus_i.addr];
    if (in_clk) begin
      next_dq = ureg[idx];
      if (idx == `NVTK_IDX_DAY) begin
        next_dq[`NVTK_BF_BIT] = backup_cell_low_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dq_o <= '0;
    end else begin
      dq_o <= next_dq;
    end
  end

  // ---------------------------------------------------------------------------
  // Power-fail gate
  // ---------------------------------------------------------------------------
  logic [RW-1:0] rec_cnt;
  logic [RW-1:0] next_rec_cnt;

  always_comb begin
    next_pf_state = pf_state;
    next_rec_cnt  = rec_cnt;
    case (pf_state)
      nvtk_pkg::NVTK_PF_OFF: begin
        next_rec_cnt = '0;
        if (power_ok_i) begin
          next_pf_state = nvtk_pkg::NVTK_PF_REC;
        end
      end
      nvtk_pkg::NVTK_PF_REC: begin
        next_rec_cnt = rec_cnt + RW'(1);
        if (!power_ok_i) begin
          next_pf_state = nvtk_pkg::NVTK_PF_OFF;
        end else if (rec_cnt == RW'(REC_CYCLES - 1)) begin
          next_pf_state = nvtk_pkg::NVTK_PF_ON;
        end
      end
      nvtk_pkg::NVTK_PF_ON: begin
        if (!power_ok_i) begin
          next_pf_state = nvtk_pkg::NVTK_PF_OFF;
        end
      end
      default: begin
        next_pf_state = nvtk_pkg::NVTK_PF_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pf_state <= nvtk_pkg::NVTK_PF_OFF;
      rec_cnt  <= '0;
      por_n_o  <= 1'b0;
    end else begin
      pf_state <= next_pf_state;
      rec_cnt  <= next_rec_cnt;
      por_n_o  <= (next_pf_state == nvtk_pkg::NVTK_PF_ON);
    end
  end

endmodule // nvtk_port

`default_nettype wire

// >>> hw/nvtk_consts.svh
// Constants for the timekeeping RAM port: addresses, bit positions, reset values, timing.
`ifndef NVTK_CONSTS_SVH
`define NVTK_CONSTS_SVH

`define NVTK_CLK_PERIOD_NS 25
`define NVTK_SEC_TIME_NS   1000000000
`define NVTK_SEC_CYCLES    (`NVTK_SEC_TIME_NS / `NVTK_CLK_PERIOD_NS)
`define NVTK_REC_TIME_US   200
`define NVTK_REC_CYCLES    ((`NVTK_REC_TIME_US * 1000) / `NVTK_CLK_PERIOD_NS)

`define NVTK_CLK_BASE      13'h1ff8
`define NVTK_IDX_CTRL      3'h0
`define NVTK_IDX_SEC       3'h1
`define NVTK_IDX_MIN       3'h2
`define NVTK_IDX_HOUR      3'h3
`define NVTK_IDX_DAY       3'h4
`define NVTK_IDX_DATE      3'h5
`define NVTK_IDX_MONTH     3'h6
`define NVTK_IDX_YEAR      3'h7

`define NVTK_WHOLD_BIT     7
`define NVTK_RHOLD_BIT     6
`define NVTK_BF_BIT        7

`define NVTK_RST_CENT      8'h20
`define NVTK_RST_YEAR      8'h00
`define NVTK_RST_MONTH     8'h01
`define NVTK_RST_DATE      8'h01
`define NVTK_RST_DAY       8'h01
`define NVTK_RST_ZERO      8'h00
`define NVTK_MAX_SEC       8'h59
`define NVTK_MAX_HOUR      8'h23
`define NVTK_MAX_DAY       8'h07
`define NVTK_MAX_MONTH     8'h12
`define NVTK_MAX_YEAR      8'h99

`endif

// >>> hw/nvtk_pkg.sv
// Types shared by the timekeeping RAM port.
`default_nettype none
package nvtk_pkg;

  typedef struct packed {
    logic [7:0] cent;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } nvtk_time_t;

  typedef struct packed {
    logic        chip_sel_n;
    logic        second_chip_select;
    logic        out_en_n;
    logic        wr_en_n;
    logic [12:0] addr;
    logic [7:0]  wdata;
  } nvtk_bus_t;

  typedef enum logic [1:0] {
    NVTK_PF_OFF,
    NVTK_PF_REC,
    NVTK_PF_ON
  } nvtk_pf_t;

endpackage

`default_nettype wire

// >>> tb/nvtk_host.sv
// Host bus model: byte-wide master of the timekeeping RAM port.
`timescale 1ns/1ps
`default_nettype none
module nvtk_host (
  input  wire logic                mclk_i,
  input  wire logic [7:0]          dq_o,
  input  wire logic                dq_oe_o,
  output var  nvtk_pkg::nvtk_bus_t bus_o,
  output logic      [7:0]          line_o
);
  // ----
  // Data lines and bus cycles
  // ----
  // A released line shows the inverse of the device's output, so a read whose
  // drive enable never rose cannot pass as good data.
  assign line_o = dq_oe_o ? dq_o : ~dq_o;
  initial bus_o = '{1'b1, 1'b0, 1'b1, 1'b1, 13'h0000, 8'h00};
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    bus_o <= '{1'b0, 1'b1, 1'b1, 1'b0, a, d};
    @(posedge mclk_i);
    bus_o <= '{1'b1, 1'b0, 1'b1, 1'b1, a, ~d};
  endtask
  task automatic rd(input logic [12:0] a, output logic [7:0] d, output logic oe);
    @(posedge mclk_i);
    bus_o <= '{1'b0, 1'b1, 1'b0, 1'b1, a, bus_o.wdata};
    @(negedge mclk_i);
    oe = dq_oe_o;
    @(posedge mclk_i);
    @(negedge mclk_i);
    d = line_o;
    @(posedge mclk_i);
    bus_o <= '{1'b1, 1'b0, 1'b1, 1'b1, a, ~bus_o.wdata};
  endtask
endmodule // nvtk_host
`default_nettype wire

// >>> tb/nvtk_checker.sv
// Checker for the timekeeping RAM port: bus decode and power-fail gate timing.
`timescale 1ns/1ps
`default_nettype none
module nvtk_checker #(
  parameter int unsigned SEC_CYCLES = 10,
  parameter int unsigned REC_CYCLES = 4
) (
  input wire logic                mclk_i,
  input wire logic                rst_n_i,
  input wire nvtk_pkg::nvtk_bus_t bus_i,
  input wire logic [7:0]          dq_o,
  input wire logic                dq_oe_o,
  input wire logic                power_ok_i,
  input wire logic                backup_cell_low_i,
  input wire logic                por_n_o
);
  // ----
  // Supply-good run length
  // ----
  // Counting good-supply edges times the gate without copying its state machine.
  logic [7:0] up_cnt;
  logic [7:0] next_up_cnt;
  always_comb begin
    next_up_cnt = up_cnt;
    if (!power_ok_i)
      next_up_cnt = 8'h00;
    else if (up_cnt != 8'hff)
      next_up_cnt = up_cnt + 8'h01;
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i)
      up_cnt <= 8'h00;
    else
      up_cnt <= next_up_cnt;
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_oe_decode: assert property (dq_oe_o == (por_n_o && !bus_i.chip_sel_n &&
    bus_i.second_chip_select && bus_i.wr_en_n && !bus_i.out_en_n))
    else $error("drive enable wrong");
  a_write_quiet: assert property (!bus_i.wr_en_n |-> !dq_oe_o)
    else $error("driven during write");
  a_pf_close: assert property (!power_ok_i |=> !por_n_o && !dq_oe_o)
    else $error("gate open in power fail");
  a_pf_fall: assert property ($fell(por_n_o) && $past(rst_n_i) |-> !$past(power_ok_i))
    else $error("reset out fell with good supply");
  a_rec_block: assert property (power_ok_i && up_cnt < REC_CYCLES |-> !por_n_o)
    else $error("gate open in recovery");
  a_rec_open: assert property (up_cnt > REC_CYCLES + 2 |-> por_n_o)
    else $error("gate shut after recovery");
  a_por_rise: assert property ($rose(por_n_o) |-> $past(power_ok_i) && $past(power_ok_i, 4))
    else $error("gate opened too early");
  a_ram_stable: assert property ($stable(bus_i) && bus_i.wr_en_n && $past(rst_n_i) &&
    bus_i.addr[12:3] != 10'h3ff && por_n_o && $past(por_n_o) |=> $stable(dq_o))
    else $error("storage byte changed without write");
endmodule // nvtk_checker
`default_nettype wire

// >>> tb/nv_timekeeping_ram_port_tb_top.sv
// Testbench for the timekeeping RAM port: storage, calendar, holds, flag, power fail.
`timescale 1ns/1ps
`default_nettype none
module nv_timekeeping_ram_port_tb_top;
  // ----
  // Harness and scenarios
  // ----
  logic                mclk;
  logic                rst_n;
  logic                power_ok;
  logic                cell_low;
  logic                dq_oe;
  logic                por_n;
  logic [7:0]          dq;
  logic [7:0]          line;
  logic [7:0]          rv;
  logic                roe;
  nvtk_pkg::nvtk_bus_t bus;
  int                  error_cnt = 0;
  int                  checks = 0;
  nvtk_port #(.SEC_CYCLES(10), .REC_CYCLES(4)) u_dut (.mclk_i(mclk), .rst_n_i(rst_n),
    .bus_i(bus), .dq_o(dq), .dq_oe_o(dq_oe), .power_ok_i(power_ok),
    .backup_cell_low_i(cell_low), .por_n_o(por_n));
  nvtk_host u_host (.mclk_i(mclk), .dq_o(dq), .dq_oe_o(dq_oe), .bus_o(bus), .line_o(line));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdc(input logic [12:0] a, input logic [7:0] exp);
    u_host.rd(a, rv, roe);
    chk($sformatf("byte %h", a), exp, rv);
  endtask
  task automatic set_time(input nvtk_pkg::nvtk_time_t tv);
    u_host.wr(13'h1ff8, 8'ha0);
    for (int i = 7; i > 0; i--)
      u_host.wr(13'h1ff8 + 13'(i), tv[8*i-8 +: 8]);
    u_host.wr(13'h1ff8, 8'h20);
  endtask
  task automatic t_reset();
    nvtk_pkg::nvtk_time_t t0 = 64'h20_00_01_01_01_00_00_00;
    @(negedge mclk);
    chk("reset out", 8'h01, {7'h0, por_n});
    rdc(13'h1ff8, 8'h20);
    for (int i = 2; i < 8; i++)
      rdc(13'h1ff8 + 13'(i), t0[8*i-8 +: 8]);
  endtask
  task automatic t_ram();
    u_host.wr(13'h0000, 8'ha5);
    u_host.wr(13'h1ff7, 8'h3c);
    u_host.wr(13'h1ff7, 8'hc3);
    rdc(13'h0000, 8'ha5);
    rdc(13'h1ff7, 8'hc3);
  endtask
  task automatic t_roll();
    nvtk_pkg::nvtk_time_t tab [10] = '{
      64'h20_24_02_28_07_23_59_59, 64'h20_24_02_29_01_00_00_00,
      64'h20_24_02_29_03_23_59_59, 64'h20_24_03_01_04_00_00_00,
      64'h20_23_02_28_03_23_59_59, 64'h20_23_03_01_04_00_00_00,
      64'h20_25_04_30_03_23_59_59, 64'h20_25_05_01_04_00_00_00,
      64'h20_25_12_31_03_23_59_59, 64'h20_26_01_01_04_00_00_00};
    for (int c = 0; c < 10; c += 2) begin
      set_time(tab[c]);
      // One tick of the shortened second lands before the hold.
      repeat (12) @(posedge mclk);
      u_host.wr(13'h1ff8, 8'h60);
      for (int i = 1; i < 8; i++)
        rdc(13'h1ff8 + 13'(i), tab[c+1][8*i-8 +: 8]);
      u_host.wr(13'h1ff8, 8'h20);
    end
  endtask
  task automatic t_hold();
    set_time(64'h20_25_06_15_02_10_20_00);
    u_host.wr(13'h1ff8, 8'h60);
    repeat (45) @(posedge mclk);
    rdc(13'h1ff9, 8'h00);
    u_host.wr(13'h1ff8, 8'h20);
    repeat (3) @(posedge mclk);
    u_host.rd(13'h1ff9, rv, roe);
    checks++;
    if (rv !== 8'h04 && rv !== 8'h05 && rv !== 8'h06) begin
      error_cnt++;
      $display("mismatch seconds expected 04 to 06 seen %h", rv);
    end
  endtask
  task automatic t_cell();
    for (int v = 1; v >= 0; v--) begin
      cell_low <= v[0];
      u_host.rd(13'h1ffc, rv, roe);
      chk("low cell flag", 8'(v), {7'h0, rv[7]});
    end
  endtask
  task automatic t_power();
    int n = 0;
    u_host.wr(13'h1ff0, 8'ha1);
    power_ok <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk("reset out", 8'h00, {7'h0, por_n});
    u_host.wr(13'h1ff0, 8'h5a);
    u_host.rd(13'h1ff0, rv, roe);
    chk("drive enable", 8'h00, {7'h0, roe});
    power_ok <= 1'b1;
    u_host.wr(13'h1ff0, 8'h77);
    @(negedge mclk);
    chk("reset out", 8'h00, {7'h0, por_n});
    while (por_n !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk("reset out", 8'h01, {7'h0, por_n});
    rdc(13'h1ff0, 8'ha1);
    u_host.wr(13'h1ff0, 8'h3e);
    rdc(13'h1ff0, 8'h3e);
  endtask
  task automatic results();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    power_ok = 1'b1;
    cell_low = 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    t_reset();
    t_ram();
    t_roll();
    t_hold();
    t_cell();
    t_power();
    results();
  end
  // The whole run needs under a thousand cycles.
  initial begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    results();
  end
endmodule // nv_timekeeping_ram_port_tb_top
bind nvtk_port nvtk_checker #(.SEC_CYCLES(SEC_CYCLES), .REC_CYCLES(REC_CYCLES)) u_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
  .power_ok_i(power_ok_i), .backup_cell_low_i(backup_cell_low_i), .por_n_o(por_n_o));
`default_nettype wire
